// file: srpg_pkg.sv
// constants, states and state layout for the sysref pulse generator
package srpg_pkg;
   localparam int ADDR_W = 5;
   localparam int CNT_W = 8;
   // register byte addresses
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_PCNT = 5'h04;
   localparam logic [4:0] ADDR_WCNT = 5'h08;
   localparam logic [4:0] ADDR_DIV = 5'h0C;
   localparam logic [4:0] ADDR_STAT = 5'h10;
   // field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_OPT_LSB = 4;
   localparam int CTRL_BIAS_BIT = 8;
   localparam int CTRL_START_BIT = 16;
   localparam int DIV_SUB_LSB = 8;
   localparam int STAT_ST_LSB = 0;
   localparam int STAT_ARMED_BIT = 2;
   localparam int STAT_LEVEL_BIT = 3;
   localparam int STAT_POWER_BIT = 4;
   localparam int STAT_GO_BIT = 5;
   // generation modes and trigger options
   localparam logic [2:0] MODE_BYPASS = 3'h0;
   localparam logic [2:0] MODE_RETIME = 3'h1;
   localparam logic [2:0] MODE_EXT = 3'h2;
   localparam logic [2:0] MODE_INT = 3'h3;
   localparam logic [2:0] MODE_CONT = 3'h4;
   localparam logic [2:0] MODE_STOP = 3'h7;
   localparam logic [1:0] OPT_00 = 2'h0;
   localparam logic [1:0] OPT_01 = 2'h1;
   // reset values and bus response codes
   localparam logic [2:0] RST_MODE = 3'h7;
   localparam logic [7:0] RST_PCNT = 8'h01;
   localparam logic [7:0] RST_WCNT = 8'h01;
   localparam logic [7:0] RST_CDIV = 8'h08;
   localparam logic [7:0] RST_SDIV = 8'h02;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_RUN = 2'h1, ST_WAIT = 2'h3} srpg_state_e;
   typedef struct packed {
      logic [2:0] mode;
      logic [1:0] opt;
      logic bias;
      logic [7:0] pcnt;
      logic [7:0] wcnt;
      logic [7:0] cdiv;
      logic [7:0] sdiv;
      logic [2:0] sync;
      logic lvl;
      logic armed;
      logic go;
      logic stop;
      logic q;
      srpg_state_e st;
      logic [7:0] ccnt;
      logic [7:0] scnt;
      logic [7:0] npulse;
      logic awv;
      logic [4:0] awa;
      logic wv;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
   } srpg_regs_s;
   localparam srpg_regs_s RST_REGS = '{mode: RST_MODE, pcnt: RST_PCNT, wcnt: RST_WCNT,
      cdiv: RST_CDIV, sdiv: RST_SDIV, st: ST_IDLE, default: '0};
endpackage

// file: srpg_top.sv
// sysref pulse generator with axi4-lite register slave
`timescale 1ns/1ns
module srpg_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [srpg_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [srpg_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_trigger_input,
   output logic sysref_p,
   output logic sysref_n,
   output logic sysref_power,
   output logic sysref_crosspoint
);
   srpg_pkg::srpg_regs_s r_reg;
   srpg_pkg::srpg_regs_s r_next;
   logic stable;
   logic rise;
   logic fall;
   logic tick;
   logic last;
   logic pdone;
   logic [8:0] half;
   logic [7:0] n1;
   logic burst;
   logic run_ok;
   logic sw_start;
   logic start_ev;
   logic stop_ev;
   logic pwr;

   // bus handshakes straight from state
   assign s_axi_awready = !r_reg.awv && !r_reg.bv;
   assign s_axi_wready = !r_reg.wv && !r_reg.bv;
   assign s_axi_bvalid = r_reg.bv;
   assign s_axi_bresp = r_reg.br;
   assign s_axi_arready = !r_reg.rv;
   assign s_axi_rvalid = r_reg.rv;
   assign s_axi_rdata = r_reg.rd;
   assign s_axi_rresp = r_reg.rr;
   // trigger edges, counted once stages two and three agree
   assign stable = r_reg.sync[1] == r_reg.sync[2];
   assign rise = stable && r_reg.sync[1] && !r_reg.lvl;
   assign fall = stable && !r_reg.sync[1] && r_reg.lvl;

   assign tick = ({1'b0, r_reg.ccnt} + 9'h001) >= {1'b0, r_reg.cdiv};
   assign last = ({1'b0, r_reg.scnt} + 9'h001) >= {1'b0, r_reg.sdiv};
   assign pdone = tick && last && (r_reg.st != srpg_pkg::ST_IDLE);
   assign half = {1'b0, r_reg.sdiv} >> 1; // odd sub-divider skews duty
   assign n1 = r_reg.npulse + 8'h01;
   assign burst = (r_reg.mode == srpg_pkg::MODE_EXT && !r_reg.opt[1]) || r_reg.mode == srpg_pkg::MODE_INT;
   assign run_ok = r_reg.mode == srpg_pkg::MODE_EXT || r_reg.mode == srpg_pkg::MODE_INT ||
      r_reg.mode == srpg_pkg::MODE_CONT;
   // stop edge opposite to start edge
   assign stop_ev = r_reg.mode == srpg_pkg::MODE_EXT && r_reg.opt[1] && (r_reg.opt[0] ? rise : fall);

   // next state: bus slave, synchroniser, pulse engine
   always_comb begin
      r_next = r_reg;
      sw_start = 1'b0;
      r_next.sync = {r_reg.sync[1:0], ext_trigger_input};
      if (stable) begin
         r_next.lvl = r_reg.sync[1];
      end
      r_next.ccnt = tick ? 8'h00 : r_reg.ccnt + 8'h01;
      // write channel, address and data in either order
      if (s_axi_awvalid && s_axi_awready) begin
         r_next.awv = 1'b1;
         r_next.awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         r_next.wv = 1'b1;
         r_next.wd = s_axi_wdata;
         r_next.ws = s_axi_wstrb;
      end
      if (r_reg.bv && s_axi_bready) begin
         r_next.bv = 1'b0;
      end
      if (r_reg.awv && r_reg.wv && !r_reg.bv) begin
         r_next.awv = 1'b0;
         r_next.wv = 1'b0;
         r_next.bv = 1'b1;
         r_next.br = srpg_pkg::RESP_OKAY;
         case (r_reg.awa)
            srpg_pkg::ADDR_CTRL: begin
               if (r_reg.ws[0]) begin
                  r_next.mode = r_reg.wd[srpg_pkg::CTRL_MODE_LSB +: 3];
                  r_next.opt = r_reg.wd[srpg_pkg::CTRL_OPT_LSB +: 2];
                  if (r_next.mode == srpg_pkg::MODE_STOP) begin
                     r_next.armed = 1'b0;
                  end
               end
               if (r_reg.ws[1]) begin
                  r_next.bias = r_reg.wd[srpg_pkg::CTRL_BIAS_BIT];
               end
               if (r_reg.ws[2]) begin
                  sw_start = r_reg.wd[srpg_pkg::CTRL_START_BIT];
               end
            end
            srpg_pkg::ADDR_PCNT: begin
               if (r_reg.ws[0]) begin
                  r_next.pcnt = r_reg.wd[srpg_pkg::CNT_W-1:0];
               end
            end
            srpg_pkg::ADDR_WCNT: begin
               if (r_reg.ws[0]) begin
                  r_next.wcnt = r_reg.wd[srpg_pkg::CNT_W-1:0];
               end
            end
            srpg_pkg::ADDR_DIV: begin
               if (r_reg.ws[0]) begin
                  r_next.cdiv = r_reg.wd[srpg_pkg::CNT_W-1:0];
               end
               if (r_reg.ws[1]) begin
                  r_next.sdiv = r_reg.wd[srpg_pkg::DIV_SUB_LSB +: srpg_pkg::CNT_W];
               end
            end
            srpg_pkg::ADDR_STAT: begin
               r_next.br = srpg_pkg::RESP_OKAY; // read-only, write dropped
            end
            default: begin
               r_next.br = srpg_pkg::RESP_DECERR;
            end
         endcase
      end
      // start bit arms the edge trigger, set beats clear
      if (sw_start) begin
         r_next.armed = 1'b1;
      end
      // start per mode
      // decoded from the mode being written, so a start bit sent with its mode counts
      start_ev = (r_next.mode == srpg_pkg::MODE_EXT && r_reg.armed && (r_next.opt[0] ? fall : rise)) ||
         (r_next.mode == srpg_pkg::MODE_INT && sw_start && !r_next.opt[1]) ||
         (r_next.mode == srpg_pkg::MODE_CONT && (r_next.opt[0] ? (r_next.opt[1] ? fall : rise) : sw_start));
      // read channel
      if (r_reg.rv && s_axi_rready) begin
         r_next.rv = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         r_next.rv = 1'b1;
         r_next.rr = srpg_pkg::RESP_OKAY;
         r_next.rd = '0;
         case (s_axi_araddr)
            srpg_pkg::ADDR_CTRL: begin
               r_next.rd[srpg_pkg::CTRL_MODE_LSB +: 3] = r_reg.mode;
               r_next.rd[srpg_pkg::CTRL_OPT_LSB +: 2] = r_reg.opt;
               r_next.rd[srpg_pkg::CTRL_BIAS_BIT] = r_reg.bias;
            end
            srpg_pkg::ADDR_PCNT: begin
               r_next.rd[srpg_pkg::CNT_W-1:0] = r_reg.pcnt;
            end
            srpg_pkg::ADDR_WCNT: begin
               r_next.rd[srpg_pkg::CNT_W-1:0] = r_reg.wcnt;
            end
            srpg_pkg::ADDR_DIV: begin
               r_next.rd[srpg_pkg::CNT_W-1:0] = r_reg.cdiv;
               r_next.rd[srpg_pkg::DIV_SUB_LSB +: srpg_pkg::CNT_W] = r_reg.sdiv;
            end
            srpg_pkg::ADDR_STAT: begin
               r_next.rd[srpg_pkg::STAT_ST_LSB +: 2] = r_reg.st;
               r_next.rd[srpg_pkg::STAT_ARMED_BIT] = r_reg.armed;
               r_next.rd[srpg_pkg::STAT_LEVEL_BIT] = r_reg.q;
               r_next.rd[srpg_pkg::STAT_POWER_BIT] = pwr;
               r_next.rd[srpg_pkg::STAT_GO_BIT] = r_reg.go;
            end
            default: begin
               r_next.rr = srpg_pkg::RESP_DECERR;
            end
         endcase
      end
      // pulse engine
      case (r_reg.st)
         srpg_pkg::ST_IDLE: begin
            r_next.stop = 1'b0;
            r_next.npulse = 8'h00;
            r_next.scnt = 8'h00;
            // start beats a clear or launch of the same cycle
            if (start_ev) begin
               r_next.go = 1'b1;
            end else if (!run_ok) begin
               r_next.go = 1'b0;
            end else if (r_reg.go && tick) begin
               r_next.go = 1'b0;
               r_next.st = srpg_pkg::ST_RUN;
            end
         end
         srpg_pkg::ST_RUN, srpg_pkg::ST_WAIT: begin
            if (tick) begin
               r_next.scnt = last ? 8'h00 : r_reg.scnt + 8'h01;
            end
            // stop request held until pulse end
            if (!run_ok || stop_ev) begin
               r_next.stop = 1'b1;
            end
            if (pdone) begin
               r_next.npulse = n1;
               if (r_reg.stop) begin
                  r_next.st = srpg_pkg::ST_IDLE;
               end else if (r_reg.st == srpg_pkg::ST_WAIT) begin
                  if (n1 >= r_reg.wcnt) begin
                     r_next.npulse = 8'h00;
                     r_next.st = srpg_pkg::ST_RUN;
                  end
               end else if (burst && n1 >= r_reg.pcnt) begin
                  r_next.npulse = 8'h00;
                  r_next.st = (r_reg.mode == srpg_pkg::MODE_INT && r_reg.opt == srpg_pkg::OPT_01) ?
                     srpg_pkg::ST_WAIT : srpg_pkg::ST_IDLE;
               end
            end
            // no pulse in flight during the gap, so stop at once
            if (r_reg.st == srpg_pkg::ST_WAIT && (!run_ok || stop_ev || r_reg.stop)) begin
               r_next.st = srpg_pkg::ST_IDLE;
            end
         end
         default: begin
            r_next.st = srpg_pkg::ST_IDLE;
         end
      endcase
      // retimed level follows the divider edge
      if (r_reg.mode == srpg_pkg::MODE_RETIME) begin
         if (tick) begin
            r_next.q = r_reg.lvl;
         end
      // high for the first half period
      end else begin
         r_next.q = (r_next.st == srpg_pkg::ST_RUN) && ({1'b0, r_next.scnt} < half);
      end
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_reg <= srpg_pkg::RST_REGS;
      end else begin
         r_reg <= r_next;
      end
   end
   assign pwr = r_reg.mode == srpg_pkg::MODE_BYPASS || r_reg.mode == srpg_pkg::MODE_RETIME ||
      r_reg.st != srpg_pkg::ST_IDLE;
   assign sysref_power = pwr;
   // raw pin path, no sampling on purpose
   assign sysref_p = (r_reg.mode == srpg_pkg::MODE_BYPASS) ? ext_trigger_input : (pwr && r_reg.q);
   // idle level set by bias select
   assign sysref_n = (r_reg.mode == srpg_pkg::MODE_BYPASS) ? !ext_trigger_input : (pwr ? !r_reg.q : !r_reg.bias);
   assign sysref_crosspoint = !pwr && r_reg.bias;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_bypass;
      r_reg.mode == srpg_pkg::MODE_BYPASS |-> sysref_p == ext_trigger_input && sysref_n != sysref_p;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass output differs from pin");
   property p_retime;
      r_reg.mode == srpg_pkg::MODE_RETIME && tick && r_reg.lvl |=> r_reg.mode != srpg_pkg::MODE_RETIME || sysref_p;
   endproperty
   a_retime: assert property (p_retime) else $error("retimed output missed divider edge");
   property p_burst_end;
      r_reg.st == srpg_pkg::ST_RUN && pdone && burst && !r_reg.stop && n1 >= r_reg.pcnt &&
         !(r_reg.mode == srpg_pkg::MODE_INT && r_reg.opt == srpg_pkg::OPT_01) |=> r_reg.st == srpg_pkg::ST_IDLE;
   endproperty
   a_burst_end: assert property (p_burst_end) else $error("burst ran past pulse count");
   property p_no_runt;
      r_reg.st == srpg_pkg::ST_RUN ##1 r_reg.st == srpg_pkg::ST_IDLE |-> $past(pdone) && !sysref_p;
   endproperty
   a_no_runt: assert property (p_no_runt) else $error("pulse cut short");
   property p_idle_low;
      !pwr && !r_reg.bias |-> !sysref_p && sysref_n && !sysref_crosspoint;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("idle level wrong for bias 0");
   property p_power;
      r_reg.st != srpg_pkg::ST_IDLE |-> sysref_power;
   endproperty
   a_power: assert property (p_power) else $error("outputs unpowered during event");
   property p_wait_end;
      r_reg.st == srpg_pkg::ST_WAIT && pdone && !r_reg.stop && run_ok && !stop_ev && n1 >= r_reg.wcnt
         |=> r_reg.st == srpg_pkg::ST_RUN;
   endproperty
   a_wait_end: assert property (p_wait_end) else $error("repeat burst did not resume");
   property p_undef;
      !run_ok && !start_ev && r_reg.st == srpg_pkg::ST_IDLE |=> r_reg.st == srpg_pkg::ST_IDLE && !r_reg.go;
   endproperty
   a_undef: assert property (p_undef) else $error("activity in non-running mode");
   property p_align;
      $rose(r_reg.q) && r_reg.mode != srpg_pkg::MODE_RETIME |-> $past(tick);
   endproperty
   a_align: assert property (p_align) else $error("pulse edge off divider edge");
   property p_sw;
      r_reg.st == srpg_pkg::ST_IDLE && r_reg.mode == srpg_pkg::MODE_INT && !r_reg.opt[1] && sw_start
         |=> r_reg.go || r_reg.st == srpg_pkg::ST_RUN;
   endproperty
   a_sw: assert property (p_sw) else $error("start bit ignored");
endmodule // srpg_top

// file: srpg_far_end.sv
// far-end model: trigger source and sysref receiver
`timescale 1ns/1ns
module srpg_far_end #(
   parameter int MIN_HOLD = 20
) (
   input wire logic aclk,
   input wire logic trig_req,
   input wire logic pulse_clr,
   input wire logic sysref_p,
   output logic ext_trigger_input,
   output logic [7:0] pulse_seen,
   output logic [7:0] last_high
);
   int hold = MIN_HOLD;
   logic prev_p = 1'b0;
   logic [7:0] hi_run = 8'h00;
   initial ext_trigger_input = 1'b0;
   initial pulse_seen = 8'h00;
   initial last_high = 8'h00;
   // slow wide trigger
   // each level held well past one divided period, so no edge is lost
   always @(posedge aclk) begin
      if (trig_req != ext_trigger_input && hold >= MIN_HOLD) begin
         ext_trigger_input <= trig_req;
         hold <= 0;
      end else if (hold < MIN_HOLD) begin
         hold <= hold + 1;
      end
   end
   // receiver: count rising edges, width of last high run
   always @(posedge aclk) begin
      prev_p <= sysref_p;
      if (pulse_clr) begin
         pulse_seen <= 8'h00;
      end else if (sysref_p && !prev_p) begin
         pulse_seen <= pulse_seen + 8'h01;
      end
      hi_run <= sysref_p ? hi_run + 8'h01 : 8'h00;
      if (!sysref_p && prev_p) begin
         last_high <= hi_run; // a runt shows as a short run
      end
   end
endmodule // srpg_far_end

// file: tb.sv
// self-checking bench for the sysref pulse generator
`timescale 1ns/1ns
module tb;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, pin, sp, sn, pwr, xp;
   logic [4:0] awaddr = 5'h00, araddr = 5'h00;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic [1:0] bresp, rresp, rs;
   logic trig_req = 0, clr = 0, lvl, prev;
   logic [7:0] npulse, lasth;
   int errors = 0, n_checks = 0, p, s, m, o;
   int unsigned cfg[5] = '{32'h40, 32'h42, 32'h41, 32'h43, 32'h31};
   always #5 aclk = ~aclk;
   srpg_top srpg_top_i(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_trigger_input(pin),
      .sysref_p(sp), .sysref_n(sn), .sysref_power(pwr), .sysref_crosspoint(xp));
   srpg_far_end srpg_far_end_i(.aclk(aclk), .trig_req(trig_req), .pulse_clr(clr), .sysref_p(sp),
      .ext_trigger_input(pin), .pulse_seen(npulse), .last_high(lasth));
   function automatic logic [31:0] ctrl(input int md, input int op, input int bias, input int st);
      return (md & 7) | ((op & 3) << 4) | ((bias & 1) << 8) | ((st & 1) << 16);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // write: address and data offered together, released as each is taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bit ad, dd;
      ad = 0;
      dd = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (!ad && awready) begin ad = 1; awvalid <= 0; end
         if (!dd && wready) begin dd = 1; wvalid <= 0; end
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      rs = bresp;
      bready <= 0;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      while (rvalid !== 1'b1) @(posedge aclk);
      rv = rdata;
      rs = rresp;
      rready <= 0;
   endtask
   // wait for an event to power up and then back down, bounded
   task automatic wait_ev();
      for (int i = 0; i < 300 && pwr !== 1'b1; i++) @(posedge aclk);
      for (int i = 0; i < 4000 && pwr !== 1'b0; i++) @(posedge aclk);
      repeat (2) @(posedge aclk);
   endtask
   task automatic pclr();
      @(posedge aclk);
      clr <= 1;
      @(posedge aclk);
      clr <= 0;
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge aclk);
      errors++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h820F));
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      chk({pwr, sp, sn}, 3'b001, "idle after reset");
      rd(srpg_pkg::ADDR_CTRL); chk(rv, 32'h7, "ctrl reset");
      rd(srpg_pkg::ADDR_PCNT); chk(rv, 32'h1, "pcnt reset");
      rd(srpg_pkg::ADDR_WCNT); chk(rv, 32'h1, "wcnt reset");
      rd(srpg_pkg::ADDR_DIV); chk(rv, 32'h208, "div reset");
      rd(srpg_pkg::ADDR_STAT); chk(rv, 32'h0, "status reset");
      rd(5'h14); chk(rs, srpg_pkg::RESP_DECERR, "unmapped read");
      wr(5'h14, 32'h1); chk(rs, srpg_pkg::RESP_DECERR, "unmapped write");
      // single bursts, random count, two sub-dividers; dividers set first channel divider 8
      for (int k = 0; k < 4; k++) begin
         s = k[0] ? 4 : 2;
         p = (k == 0) ? 1 : $urandom_range(2, 6);
         wr(srpg_pkg::ADDR_DIV, (s << 8) | 8);
         wr(srpg_pkg::ADDR_PCNT, p);
         chk(rs, srpg_pkg::RESP_OKAY, "write response");
         pclr();
         wr(srpg_pkg::ADDR_CTRL, ctrl(3, 0, 0, 1));
         wait_ev();
         chk(npulse, p, "burst count");
         chk(lasth, (s / 2) * 8, "pulse high width");
         chk({pwr, sn}, 2'b01, "idle after burst");
      end
      wr(srpg_pkg::ADDR_DIV, 32'h208);
      wr(srpg_pkg::ADDR_PCNT, 3);
      wr(srpg_pkg::ADDR_WCNT, 2);
      // external trigger, all four options; start bit arms first
      for (o = 0; o < 4; o++) begin
         lvl = o[0];
         wr(srpg_pkg::ADDR_CTRL, ctrl(7, 0, 0, 0));
         trig_req <= lvl;
         repeat (50) @(posedge aclk);
         wr(srpg_pkg::ADDR_CTRL, ctrl(2, o, 0, 1));
         pclr();
         trig_req <= !lvl;
         if (o >= 2) repeat (400) @(posedge aclk);
         if (o >= 2) trig_req <= lvl;
         wait_ev();
         if (o < 2) chk(npulse, 3, "edge burst count");
         else chk(npulse >= 20 && npulse <= 27, 1, "start stop edges");
         chk({pwr, lasth}, {1'b0, 8'h08}, "stopped whole");
      end
      // continuous by start bit or edges, then repeating bursts; each stopped by mode 111
      for (int k = 0; k < 5; k++) begin
         m = cfg[k] >> 4;
         o = cfg[k] & 3;
         lvl = (o == 3);
         wr(srpg_pkg::ADDR_CTRL, ctrl(7, 0, 0, 0));
         trig_req <= lvl;
         repeat (50) @(posedge aclk);
         pclr();
         wr(srpg_pkg::ADDR_CTRL, ctrl(m, o, 0, (m == 3 || o[0] == 0)));
         trig_req <= !lvl;
         repeat (300) @(posedge aclk);
         wr(srpg_pkg::ADDR_CTRL, ctrl(7, 0, 0, 0));
         wait_ev();
         if (m == 4) chk(npulse >= 15 && npulse <= 21, 1, "continuous count");
         else chk(npulse >= 8 && npulse <= 14, 1, "repeat with gaps");
         chk({pwr, lasth}, {1'b0, 8'h08}, "no runt at stop");
      end
      // undefined modes with crosspoint idle bias
      for (m = 5; m < 7; m++) begin
         wr(srpg_pkg::ADDR_CTRL, ctrl(m, 0, 1, 1));
         pclr();
         trig_req <= !trig_req;
         repeat (100) @(posedge aclk);
         chk({npulse, pwr}, 9'h0, "undefined mode idle");
         chk({xp, sp, sn}, 3'b100, "crosspoint idle");
      end
      // bypass and retimed pass-through
      for (m = 0; m < 2; m++) begin
         wr(srpg_pkg::ADDR_CTRL, ctrl(m, 0, 0, 0));
         repeat (30) @(posedge aclk);
         for (int k = 0; k < 4; k++) begin
            prev = pin;
            trig_req <= !prev;
            repeat (3) @(posedge aclk);
            if (m == 1) chk(sp, prev, "retime holds old level");
            else chk({sp, sn}, {!prev, prev}, "bypass follows pin");
            repeat (30) @(posedge aclk);
            chk({sp, sn, pwr}, {!prev, prev, 1'b1}, "pass-through level");
         end
      end
      end_of_test();
   end
endmodule // tb
